// file: core/gpio_pkg.sv
// Constants, register map and field layout for the shared-pin I/O port
//////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Direction one means input, zero drives
// R2: Reset sets every direction bit to input
// R3: Latch reads latch, writes update latch
// R4: Pin register reads pins, writes latch
// R5: Unimplemented bits read as zero
// R6: Active peripheral owns pin, port driver off
// R7: Idle enabled peripheral leaves pin to port
// R8: Port output never loops into peripheral input
// R9: Open-drain pins only pull low
// R10: Analog pins read low in pin register
// R11: Software sets analog pins as inputs
// R12: Software waits one cycle before reading back
// R13: Change on selected input raises interrupt
// R14: Per-input change enable gates the interrupt
// R15: Separate weak pull-up and pull-down enables
// R16: Software disables pull-up on output pins
// R17: Input-only shared pins belong to port
// R18: Digital inputs not connected to converter
// R19: Change flag sticks until software clears
package gpio_pkg;

  // Port width and per-device implementation
  localparam int           PIN_W        = 16;
  localparam logic [15:0]  IMPL_MASK    = 16'h7fff;  // Bit 15 absent on this device
  localparam logic [15:0]  PERIPH_OUT   = 16'h0fff;  // Pins whose peripheral can drive

  // Bus geometry
  localparam int           ADDR_W       = 8;
  localparam int           DATA_W       = 32;

  // Register byte offsets
  localparam logic [7:0]   OFS_DIR      = 8'h00;
  localparam logic [7:0]   OFS_LATCH    = 8'h04;
  localparam logic [7:0]   OFS_PIN      = 8'h08;
  localparam logic [7:0]   OFS_ODSEL    = 8'h0c;
  localparam logic [7:0]   OFS_ANALOG   = 8'h10;
  localparam logic [7:0]   OFS_CHG_EN   = 8'h14;
  localparam logic [7:0]   OFS_PULLUP   = 8'h18;
  localparam logic [7:0]   OFS_PULLDN   = 8'h1c;
  localparam logic [7:0]   OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0]   OFS_IRQ_MASK = 8'h24;

  // Reset values
  localparam logic [15:0]  RST_DIR      = 16'hffff;
  localparam logic [15:0]  RST_ZERO     = 16'h0000;

  // AHB encodings
  localparam logic [1:0]   HTRANS_NSEQ  = 2'h2;
  localparam logic [1:0]   HTRANS_SEQ   = 2'h3;
  localparam logic         HRESP_OKAY   = 1'h0;

endpackage

// file: core/gpio_reg_if.sv
// Register access carrier between bus front end and the port core
`timescale 1ns/10ps
interface gpio_reg_if;
  logic                              wr_en;
  logic [gpio_pkg::ADDR_W-1:0]       wr_addr;
  logic [gpio_pkg::DATA_W-1:0]       wr_data;
  logic                              rd_en;
  logic [gpio_pkg::ADDR_W-1:0]       rd_addr;
  logic [gpio_pkg::DATA_W-1:0]       rd_data;

  modport front (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_en,
    output rd_addr,
    input  rd_data
  );
  modport regs (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  rd_en,
    input  rd_addr,
    output rd_data
  );
endinterface

// file: core/gpio_ahb_front.sv
// AHB-Lite slave front end: address capture, write strobe, read data register
`timescale 1ns/10ps
module gpio_ahb_front (
  input  wire logic                          i_mclk,
  input  wire logic                          i_sys_rst,
  input  wire logic                          i_hsel,
  input  wire logic [31:0]                   i_haddr,
  input  wire logic [1:0]                    i_htrans,
  input  wire logic                          i_hwrite,
  input  wire logic [31:0]                   i_hwdata,
  input  wire logic                          i_hready,
  output logic      [31:0]                   o_hrdata,
  output logic                               o_hreadyout,
  output logic                               o_hresp,
  gpio_reg_if.front                          bus
);
  logic                                      wr_pend_reg;
  logic [gpio_pkg::ADDR_W-1:0]               wr_addr_reg;
  logic                                      take;

  // Valid address phase seen by this slave
  assign take = i_hsel & i_hready &
                ((i_htrans == gpio_pkg::HTRANS_NSEQ) | (i_htrans == gpio_pkg::HTRANS_SEQ));

  // Write address held into the data phase
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= take & i_hwrite;
      wr_addr_reg <= i_haddr[gpio_pkg::ADDR_W-1:0];
    end
  end

  // Write strobe with data phase data
  assign bus.wr_en   = wr_pend_reg;
  assign bus.wr_addr = wr_addr_reg;
  assign bus.wr_data = i_hwdata;

  // Read decoded in address phase, registered for the data phase
  assign bus.rd_en   = take & ~i_hwrite;
  assign bus.rd_addr = i_haddr[gpio_pkg::ADDR_W-1:0];

  // Zero wait states, always OKAY
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_hrdata    <= '0;
      o_hreadyout <= 1'b0;
      o_hresp     <= gpio_pkg::HRESP_OKAY;
    end else begin
      if (bus.rd_en) begin
        o_hrdata <= bus.rd_data;
      end
      o_hreadyout <= 1'b1;
      o_hresp     <= gpio_pkg::HRESP_OKAY;
    end
  end
endmodule

// file: core/gpio_pin_mux.sv
// Output ownership, open-drain shaping and input gating for one pin
`timescale 1ns/10ps
module gpio_pin_mux #(
  parameter bit OUT_CAPABLE = 1'b1,
  parameter bit IMPL        = 1'b1
) (
  input  wire logic i_dir,
  input  wire logic i_latch,
  input  wire logic i_od_sel,
  input  wire logic i_analog,
  input  wire logic i_periph_en,
  input  wire logic i_periph_drive,
  input  wire logic i_periph_out,
  input  wire logic i_periph_oe,
  input  wire logic i_pin_in,
  output logic      o_pin_out,
  output logic      o_pin_oe,
  output logic      o_periph_in,
  output logic      o_pin_level
);
  logic periph_owns;
  logic port_drive;
  logic data;
  logic oe_raw;

  // Ownership: active peripheral wins, idle or input-only leaves it to port
  assign periph_owns = IMPL & OUT_CAPABLE & i_periph_en & i_periph_drive; // R6 R7 R17
  assign port_drive  = IMPL & ~periph_owns & ~i_dir;                      // R1 R6
  assign data        = periph_owns ? i_periph_out : i_latch;
  assign oe_raw      = periph_owns ? i_periph_oe : port_drive;

  // Open-drain never drives high
  assign o_pin_out   = i_od_sel ? 1'b0 : data;                            // R9
  assign o_pin_oe    = i_od_sel ? (oe_raw & ~data) : oe_raw;              // R9

  // Block loop-through and analog levels toward the peripheral
  assign o_periph_in = IMPL & ~port_drive & ~i_analog & i_pin_in;         // R8
  // Pin level readback, analog and absent bits read low
  assign o_pin_level = IMPL & ~i_analog & i_pin_in;                       // R5 R10
endmodule

// file: core/gpio_port.sv
// Shared-pin parallel I/O port with change notification and AHB-Lite registers
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module gpio_port (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Pins
  input  wire logic [15:0] i_pin_in,
  output logic      [15:0] o_pin_out,
  output logic      [15:0] o_pin_oe,
  output logic      [15:0] o_pullup_en,
  output logic      [15:0] o_pulldown_en,
  // Sharing peripherals
  input  wire logic [15:0] i_periph_en,
  input  wire logic [15:0] i_periph_drive,
  input  wire logic [15:0] i_periph_out,
  input  wire logic [15:0] i_periph_oe,
  output logic      [15:0] o_periph_in,
  // Converter input switches
  output logic      [15:0] o_adc_connect,
  // Interrupt
  output logic             o_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int W = gpio_pkg::PIN_W;

  gpio_reg_if bus ();

  logic [W-1:0] pin_direction_reg;
  logic [W-1:0] output_holding_reg;
  logic [W-1:0] open_drain_select_reg;
  logic [W-1:0] analog_pin_config_reg;
  logic [W-1:0] change_irq_enable_reg;
  logic [W-1:0] weak_pullup_enable_reg;
  logic [W-1:0] weak_pulldown_enable_reg;
  logic [W-1:0] change_notice_reg;
  logic [W-1:0] irq_mask_reg;
  logic [W-1:0] prev_pin_reg;

  logic [W-1:0] wdata16;
  logic [W-1:0] mux_out;
  logic [W-1:0] mux_oe;
  logic [W-1:0] mux_periph_in;
  logic [W-1:0] pin_level;
  logic [W-1:0] change_hit;
  logic [W-1:0] change_notice_next;
  logic [W-1:0] rd_word;

  logic         wr_dir;
  logic         wr_latch;
  logic         wr_odsel;
  logic         wr_analog;
  logic         wr_chg_en;
  logic         wr_pullup;
  logic         wr_pulldn;
  logic         wr_stat;
  logic         wr_mask;

  //////////////////////////////////////////////////////////////////////////////
  // Bus front end

  gpio_ahb_front u_front (
    .i_mclk      (i_mclk),
    .i_sys_rst   (i_sys_rst),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hrdata    (o_hrdata),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .bus         (bus.front)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write decode

  // Only implemented bits are ever stored
  assign wdata16   = bus.wr_data[W-1:0] & gpio_pkg::IMPL_MASK;            // R5

  // One strobe per register
  assign wr_dir    = bus.wr_en & (bus.wr_addr == gpio_pkg::OFS_DIR);
  assign wr_latch  = bus.wr_en & ((bus.wr_addr == gpio_pkg::OFS_LATCH) |
                                  (bus.wr_addr == gpio_pkg::OFS_PIN));    // R3 R4
  assign wr_odsel  = bus.wr_en & (bus.wr_addr == gpio_pkg::OFS_ODSEL);
  assign wr_analog = bus.wr_en & (bus.wr_addr == gpio_pkg::OFS_ANALOG);
  assign wr_chg_en = bus.wr_en & (bus.wr_addr == gpio_pkg::OFS_CHG_EN);
  assign wr_pullup = bus.wr_en & (bus.wr_addr == gpio_pkg::OFS_PULLUP);
  assign wr_pulldn = bus.wr_en & (bus.wr_addr == gpio_pkg::OFS_PULLDN);
  assign wr_stat   = bus.wr_en & (bus.wr_addr == gpio_pkg::OFS_IRQ_STAT);
  assign wr_mask   = bus.wr_en & (bus.wr_addr == gpio_pkg::OFS_IRQ_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // Port control registers

  // Direction, all inputs after reset
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pin_direction_reg <= gpio_pkg::RST_DIR & gpio_pkg::IMPL_MASK;       // R2 R5
    end else if (wr_dir) begin
      pin_direction_reg <= wdata16;                                       // R1
    end
  end

  // Output latch, written through either the latch or the pin address
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      output_holding_reg <= gpio_pkg::RST_ZERO;
    end else if (wr_latch) begin
      output_holding_reg <= wdata16;                                      // R3 R4
    end
  end

  // Open-drain select
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      open_drain_select_reg <= gpio_pkg::RST_ZERO;
    end else if (wr_odsel) begin
      open_drain_select_reg <= wdata16;                                   // R9
    end
  end

  // Analog pin configuration
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      analog_pin_config_reg <= gpio_pkg::RST_ZERO;
    end else if (wr_analog) begin
      analog_pin_config_reg <= wdata16;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Change notification and weak pull registers

  // Per-input change enables
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      change_irq_enable_reg <= gpio_pkg::RST_ZERO;
    end else if (wr_chg_en) begin
      change_irq_enable_reg <= wdata16;                                   // R14
    end
  end

  // Weak pull-up enables
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      weak_pullup_enable_reg <= gpio_pkg::RST_ZERO;
    end else if (wr_pullup) begin
      weak_pullup_enable_reg <= wdata16;                                  // R15
    end
  end

  // Weak pull-down enables
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      weak_pulldown_enable_reg <= gpio_pkg::RST_ZERO;
    end else if (wr_pulldn) begin
      weak_pulldown_enable_reg <= wdata16;                                // R15
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      irq_mask_reg <= gpio_pkg::RST_ZERO;
    end else if (wr_mask) begin
      irq_mask_reg <= wdata16;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-pin ownership muxes

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      gpio_pin_mux #(
        .OUT_CAPABLE (gpio_pkg::PERIPH_OUT[g]),
        .IMPL        (gpio_pkg::IMPL_MASK[g])
      ) u_mux (
        .i_dir          (pin_direction_reg[g]),
        .i_latch        (output_holding_reg[g]),
        .i_od_sel       (open_drain_select_reg[g]),
        .i_analog       (analog_pin_config_reg[g]),
        .i_periph_en    (i_periph_en[g]),
        .i_periph_drive (i_periph_drive[g]),
        .i_periph_out   (i_periph_out[g]),
        .i_periph_oe    (i_periph_oe[g]),
        .i_pin_in       (i_pin_in[g]),
        .o_pin_out      (mux_out[g]),
        .o_pin_oe       (mux_oe[g]),
        .o_periph_in    (mux_periph_in[g]),
        .o_pin_level    (pin_level[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Registered pin-side outputs

  // Pin drivers take effect one cycle after the register write
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_pin_out <= '0;
      o_pin_oe  <= '0;                                                    // R2
    end else begin
      o_pin_out <= mux_out;                                               // R12
      o_pin_oe  <= mux_oe;                                                // R1 R6
    end
  end

  // Gated pin level toward the sharing peripherals
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_periph_in <= '0;
    end else begin
      o_periph_in <= mux_periph_in;                                       // R8
    end
  end

  // Weak pulls to the pad
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_pullup_en   <= '0;
      o_pulldown_en <= '0;
    end else begin
      o_pullup_en   <= weak_pullup_enable_reg;                            // R15
      o_pulldown_en <= weak_pulldown_enable_reg;                          // R15
    end
  end

  // Converter switch only on analog-configured pins
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_adc_connect <= '0;
    end else begin
      o_adc_connect <= analog_pin_config_reg & gpio_pkg::IMPL_MASK;       // R18
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Change detection

  // Previous level; holds across a stopped clock so a change is still caught
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      prev_pin_reg <= gpio_pkg::RST_ZERO;
    end else begin
      prev_pin_reg <= i_pin_in & gpio_pkg::IMPL_MASK;                     // R13
    end
  end

  // Enabled inputs that differ from the recorded level
  assign change_hit = change_irq_enable_reg & gpio_pkg::IMPL_MASK &
                      (i_pin_in ^ prev_pin_reg);                          // R13 R14

  // Sticky flags, write one to clear, a new change wins over the clear
  always_comb begin
    change_notice_next = change_notice_reg;
    if (wr_stat) begin
      change_notice_next = change_notice_next & ~wdata16;
    end
    change_notice_next = change_notice_next | change_hit;                 // R19
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      change_notice_reg <= gpio_pkg::RST_ZERO;
    end else begin
      change_notice_reg <= change_notice_next;                            // R19
    end
  end

  // Level interrupt while an unmasked flag is set
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(change_notice_next & irq_mask_reg);                      // R13
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read decode

  // Latch reads latch, pin address reads gated pin levels
  always_comb begin
    case (bus.rd_addr)
      gpio_pkg::OFS_DIR:      rd_word = pin_direction_reg;
      gpio_pkg::OFS_LATCH:    rd_word = output_holding_reg;               // R3
      gpio_pkg::OFS_PIN:      rd_word = pin_level;                        // R4 R10
      gpio_pkg::OFS_ODSEL:    rd_word = open_drain_select_reg;
      gpio_pkg::OFS_ANALOG:   rd_word = analog_pin_config_reg;
      gpio_pkg::OFS_CHG_EN:   rd_word = change_irq_enable_reg;
      gpio_pkg::OFS_PULLUP:   rd_word = weak_pullup_enable_reg;
      gpio_pkg::OFS_PULLDN:   rd_word = weak_pulldown_enable_reg;
      gpio_pkg::OFS_IRQ_STAT: rd_word = change_notice_reg;
      gpio_pkg::OFS_IRQ_MASK: rd_word = irq_mask_reg;
      default:                rd_word = '0;
    endcase
  end

  // Absent bits and upper half read as zero
  assign bus.rd_data = {16'h0000, rd_word & gpio_pkg::IMPL_MASK};         // R5

endmodule

// file: bench/gpio_port_monitor.sv
// Port-level checker for the shared-pin I/O port
`timescale 1ns/10ps
module gpio_port_monitor (
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_hsel,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic        i_hready,
  input  wire logic [15:0] i_pin_in,
  input  wire logic [15:0] i_periph_en,
  input  wire logic [15:0] i_periph_drive,
  input  wire logic [15:0] i_periph_out,
  input  wire logic [15:0] i_periph_oe,
  input  wire logic        o_hreadyout,
  input  wire logic        o_hresp,
  input  wire logic [15:0] o_pin_out,
  input  wire logic [15:0] o_pin_oe,
  input  wire logic [15:0] o_periph_in,
  input  wire logic [15:0] o_adc_connect,
  input  wire logic        o_irq
);
  logic [15:0] own;
  logic [3:0]  wr_hist;
  // Pins a peripheral may take over
  assign own = i_periph_en & i_periph_drive & gpio_pkg::PERIPH_OUT;
  // Recent taken bus writes
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wr_hist <= 4'h0;
    end else begin
      wr_hist <= {wr_hist[2:0], i_hsel & i_hready & i_htrans[1] & i_hwrite};
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // Ownership, gating and interrupt relations
  reset_quiet_a: assert property ($fell(i_sys_rst) |-> !o_irq && o_pin_oe == 16'h0 ##1
    o_hreadyout && (o_pin_oe & ~gpio_pkg::PERIPH_OUT) == 16'h0) else $error("reset state wrong");
  bus_okay_a: assert property (!$past(i_sys_rst) |-> o_hreadyout
    && o_hresp == gpio_pkg::HRESP_OKAY) else $error("bus answer wrong");
  periph_release_a: assert property (!$past(i_sys_rst) |->
    (o_pin_oe & $past(own & ~i_periph_oe)) == 16'h0) else $error("port drives owned pin");
  periph_drive_a: assert property (!$past(i_sys_rst) |->
    (~o_pin_oe & $past(own & i_periph_oe & ~i_periph_out)) == 16'h0
    && ((o_pin_oe ^ o_pin_out) & $past(own & i_periph_oe & i_periph_out)) == 16'h0
    && (o_pin_out & $past(own & ~i_periph_out)) == 16'h0) else $error("peripheral data lost");
  no_loop_a: assert property (!$past(i_sys_rst) |->
    (o_periph_in & o_pin_oe & ~$past(own)) == 16'h0) else $error("port output loops back");
  analog_zero_a: assert property (
    (o_periph_in & o_adc_connect & $past(o_adc_connect)) == 16'h0)
    else $error("analog pin reads high");
  absent_bit_a: assert property (o_pin_oe[15] == 1'b0 && o_pin_out[15] == 1'b0
    && o_periph_in[15] == 1'b0) else $error("absent pin active");
  input_only_a: assert property (!$past(i_sys_rst) && $changed(o_pin_oe[14:12]) |->
    |wr_hist) else $error("input-only pin taken");
  irq_clear_a: assert property (!$past(i_sys_rst) && $fell(o_irq) |-> |wr_hist)
    else $error("irq dropped alone");
  irq_cause_a: assert property ($rose(o_irq) |-> |wr_hist
    || $past(i_pin_in) != $past(i_pin_in, 2) || $past(i_pin_in, 2) != $past(i_pin_in, 3))
    else $error("irq without change");
  irq_seen_c: cover property ($rose(o_irq));
  owned_c: cover property (|own);
  analog_c: cover property (|o_adc_connect);
endmodule
bind gpio_port gpio_port_monitor mon (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .i_pin_in(i_pin_in),
  .i_periph_en(i_periph_en), .i_periph_drive(i_periph_drive), .i_periph_out(i_periph_out),
  .i_periph_oe(i_periph_oe), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_periph_in(o_periph_in),
  .o_adc_connect(o_adc_connect), .o_irq(o_irq));

// file: bench/gpio_pad_model.sv
// Pad model: outside drivers, weak pulls and floating pins
`timescale 1ns/10ps
module gpio_pad_model (
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_pin_out,
  input  wire logic [15:0] i_pin_oe,
  input  wire logic [15:0] i_pullup_en,
  input  wire logic [15:0] i_pulldown_en,
  input  wire logic [15:0] i_ext_en,
  input  wire logic [15:0] i_ext_val,
  output logic      [15:0] o_pad
);
  logic [15:0] float_reg = 16'h0;
  // Undriven pins without a pull wander every cycle
  always @(posedge i_mclk) begin
    float_reg <= ~o_pad;
  end
  // Wire level: pad driver, outside driver, then weak pulls
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (i_pin_oe[i]) begin
        o_pad[i] = i_pin_out[i];
      end else if (i_ext_en[i]) begin
        o_pad[i] = i_ext_val[i];
      end else if (i_pullup_en[i]) begin
        o_pad[i] = 1'b1;
      end else if (i_pulldown_en[i]) begin
        o_pad[i] = 1'b0;
      end else begin
        o_pad[i] = float_reg[i];
      end
    end
  end
endmodule

// file: bench/gpio_port_bench.sv
// Self-checking bench for the shared-pin I/O port
`timescale 1ns/10ps
module gpio_port_bench;
  logic        mclk, sys_rst, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] pin_in, pin_out, pin_oe, pu_en, pd_en, p_en, p_drv, p_out, p_oe, p_in, adc;
  logic [15:0] ext_en, ext_val;
  int          errors, cmp_count;
  //////////////////////////////////////////////////////////////////////////////
  // Design, pads and clock
  gpio_port dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pullup_en(pu_en),
    .o_pulldown_en(pd_en), .i_periph_en(p_en), .i_periph_drive(p_drv), .i_periph_out(p_out),
    .i_periph_oe(p_oe), .o_periph_in(p_in), .o_adc_connect(adc), .o_irq(irq));
  gpio_pad_model pad (.i_mclk(mclk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .i_pullup_en(pu_en), .i_pulldown_en(pd_en), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_pad(pin_in));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Bus cycle, compare and verdict
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= gpio_pkg::HTRANS_NSEQ;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask
  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge mclk);
    errors++;
    end_sim;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    errors = 0;
    cmp_count = 0;
    sys_rst <= 1'b1;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= 32'h0;
    {p_en, p_drv, p_out, p_oe} <= 64'h0;
    ext_en <= 16'hef00;
    ext_val <= 16'hac00;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    // Reset values, latch and pin register writes
    rchk(gpio_pkg::OFS_DIR, 32'h7fff);
    chk({16'h0, pin_oe}, 32'h0);
    bus(gpio_pkg::OFS_LATCH, 1'b1, 32'hffff_ffff);
    rchk(gpio_pkg::OFS_LATCH, 32'h7fff);
    bus(gpio_pkg::OFS_PIN, 1'b1, 32'h10a5);
    rchk(gpio_pkg::OFS_LATCH, 32'h10a5);
    bus(gpio_pkg::OFS_DIR, 1'b1, 32'hef00);
    rchk(gpio_pkg::OFS_DIR, 32'h6f00);
    settle;
    chk({pin_oe, pin_out & pin_oe}, 32'h10ff_10a5);
    rchk(gpio_pkg::OFS_PIN, 32'h3ca5);
    // Analog pins read low and connect to the converter
    bus(gpio_pkg::OFS_ANALOG, 1'b1, 32'h2400);
    settle;
    rchk(gpio_pkg::OFS_PIN, 32'h18a5);
    chk({adc, p_in}, 32'h2400_0800);
    bus(gpio_pkg::OFS_ANALOG, 1'b1, 32'h0);
    // Open drain on a high and a low latch bit
    bus(gpio_pkg::OFS_ODSEL, 1'b1, 32'h3);
    settle;
    chk({28'h0, pin_oe[1:0], pin_out[1:0]}, 32'h8);
    bus(gpio_pkg::OFS_ODSEL, 1'b1, 32'h0);
    bus(gpio_pkg::OFS_PULLUP, 1'b1, 32'h0200);
    bus(gpio_pkg::OFS_PULLDN, 1'b1, 32'h4000);
    settle;
    chk({pu_en, pd_en}, 32'h0200_4000);
    // Peripherals take pins 0 and 1, pin 12 stays with the port
    ext_en <= 16'hef02;
    ext_val <= 16'h2c02;
    {p_en, p_drv, p_oe, p_out} <= 64'hffff_1003_fffd_0000;
    settle;
    chk({pin_oe, pin_out & pin_oe}, 32'h10fd_10a4);
    chk({16'h0, p_in}, 32'h2c02);
    rchk(gpio_pkg::OFS_PIN, 32'h3ca6);
    p_drv <= 16'h0;
    settle;
    chk({pin_oe, pin_out & pin_oe}, 32'h10ff_10a5);
    p_en <= 16'h0;
    // Change notice, mask and sticky status
    bus(gpio_pkg::OFS_CHG_EN, 1'b1, 32'h0100);
    bus(gpio_pkg::OFS_IRQ_MASK, 1'b1, 32'h0100);
    bus(gpio_pkg::OFS_IRQ_STAT, 1'b1, 32'hffff);
    ext_val <= 16'h2e00;
    settle;
    chk({31'h0, irq}, 32'h0);
    rchk(gpio_pkg::OFS_IRQ_STAT, 32'h0);
    ext_val <= 16'h2f00;
    settle;
    chk({31'h0, irq}, 32'h1);
    ext_val <= 16'h2e00;
    settle;
    rchk(gpio_pkg::OFS_IRQ_STAT, 32'h0100);
    bus(gpio_pkg::OFS_IRQ_MASK, 1'b1, 32'h0);
    settle;
    chk({31'h0, irq}, 32'h0);
    bus(gpio_pkg::OFS_IRQ_MASK, 1'b1, 32'h0100);
    settle;
    chk({31'h0, irq}, 32'h1);
    bus(gpio_pkg::OFS_IRQ_STAT, 1'b1, 32'h0100);
    settle;
    chk({31'h0, irq}, 32'h0);
    rchk(gpio_pkg::OFS_IRQ_STAT, 32'h0);
    // Unmapped place, then a reset in mid-run
    bus(8'h30, 1'b1, 32'hffff_ffff);
    rchk(8'h30, 32'h0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({16'h0, pin_oe}, 32'h0);
    rchk(gpio_pkg::OFS_DIR, 32'h7fff);
    end_sim;
  end
endmodule
